// ==== design/pieme_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module pieme_top
   import pieme_pkg::*;
(
   input  wire logic                      mclk,
   input  wire logic                      arst_n,
   input  wire logic                      clk_en,
   input  wire pieme_pkg::pieme_sfr_req_s sfr_req,
   output logic [7:0]                     sfr_rdata,
   output logic                           sfr_hit,
   input  wire pieme_pkg::pieme_src_s     src,
   output logic [7:0]                     irq_req
);
   import pieme_pkg::*;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta_n;
   logic rst_n;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // ------------------------------------------------------------
   // enable register
   // ------------------------------------------------------------
   logic [7:0]      peripheral_interrupt_enables;
   wire logic       sel;
   wire logic       wr_en;
   wire logic [7:0] next_enables;

   assign sel   = (sfr_req.addr == PIEME_ENABLES_ADDR);
   assign wr_en = clk_en & sfr_req.wr & sel;
   // reserved position forced low so a stray one never sticks
   assign next_enables = sfr_req.wdata & ~PIEME_RESERVED_MASK;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         peripheral_interrupt_enables <= PIEME_ENABLES_RESET;
      end else if (wr_en) begin
         peripheral_interrupt_enables <= next_enables;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   wire logic       rd_hit;
   wire logic [7:0] next_rdata;

   assign rd_hit = sfr_req.rd & sel;
   // a miss returns zero so unmapped reads never echo the register
   assign next_rdata = rd_hit
                     ? (peripheral_interrupt_enables & ~PIEME_RESERVED_MASK)
                     : 8'h00;

   // read data registered; hit is combinational handshake
   assign sfr_hit = sel & (sfr_req.rd | sfr_req.wr);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (clk_en) begin
         sfr_rdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // request gating
   // ------------------------------------------------------------
   wire logic [7:0] gated;

   pieme_gate u_gate (
      .src     (src),
      .enables (peripheral_interrupt_enables),
      .gated   (gated)
   );

   // registered so the core sees glitch-free requests
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_req <= 8'h00;
      end else if (clk_en) begin
         irq_req <= gated;
      end
   end

   // ------------------------------------------------------------
   // checks: request gating
   // ------------------------------------------------------------
   a_timer_gate: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clk_en |=> irq_req[PIEME_BIT_TIMER3]
         == ($past(src.timer_three_flag)
             & $past(peripheral_interrupt_enables[PIEME_BIT_TIMER3])))
      else $error("timer three gating wrong");

   a_cmp0_gate: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clk_en |=> irq_req[PIEME_BIT_CMP0]
         == (($past(src.comparator_zero_rise_flag)
              | $past(src.comparator_zero_fall_flag))
             & $past(peripheral_interrupt_enables[PIEME_BIT_CMP0])))
      else $error("comparator zero gating wrong");

   a_cntarr_gate: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clk_en && !peripheral_interrupt_enables[PIEME_BIT_CNTARR]
      |=> !irq_req[PIEME_BIT_CNTARR])
      else $error("counter array not blocked");

   a_cntarr_pass: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clk_en |=> irq_req[PIEME_BIT_CNTARR]
         == ($past(src.counter_array_flag)
             & $past(peripheral_interrupt_enables[PIEME_BIT_CNTARR])))
      else $error("counter array gating wrong");

   a_conv_gate: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clk_en && src.conversion_done_flag
      && peripheral_interrupt_enables[PIEME_BIT_CONV]
      |=> irq_req[PIEME_BIT_CONV])
      else $error("conversion done not forwarded");

   a_conv_block: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clk_en && !peripheral_interrupt_enables[PIEME_BIT_CONV]
      |=> !irq_req[PIEME_BIT_CONV])
      else $error("conversion done not blocked");

   a_window_gate: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clk_en |=> irq_req[PIEME_BIT_WINDOW]
         == ($past(src.window_compare_flag)
             & $past(peripheral_interrupt_enables[PIEME_BIT_WINDOW])))
      else $error("window compare gating wrong");

   a_rsvd_zero: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !peripheral_interrupt_enables[PIEME_BIT_RSVD]
      && !sfr_rdata[PIEME_BIT_RSVD] && !irq_req[PIEME_BIT_RSVD])
      else $error("reserved bit not zero");

   a_twowire_gate: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clk_en |=> irq_req[PIEME_BIT_TWOWIRE]
         == ($past(src.two_wire_flag)
             & $past(peripheral_interrupt_enables[PIEME_BIT_TWOWIRE])))
      else $error("two-wire gating wrong");

   a_cmp1_gate: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clk_en |=> irq_req[PIEME_BIT_CMP1]
         == (($past(src.comparator_one_rise_flag)
              | $past(src.comparator_one_fall_flag))
             & $past(peripheral_interrupt_enables[PIEME_BIT_CMP1])))
      else $error("comparator one gating wrong");

   // ------------------------------------------------------------
   // checks: register access and reset
   // ------------------------------------------------------------
   a_write_lands: assert property (
      @(posedge mclk) disable iff (!rst_n)
      wr_en |=> peripheral_interrupt_enables == $past(next_enables))
      else $error("register write lost");

   a_read_data: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clk_en && rd_hit
      |=> sfr_rdata == ($past(peripheral_interrupt_enables)
                       & ~PIEME_RESERVED_MASK))
      else $error("read data wrong");

   a_miss_zero: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clk_en && !rd_hit |=> sfr_rdata == 8'h00)
      else $error("refused read returned data");

   // a foreign address must leave the register alone
   a_ignore_miss: assert property (
      @(posedge mclk) disable iff (!rst_n)
      sfr_req.wr && !sel |=> $stable(peripheral_interrupt_enables))
      else $error("foreign write changed register");

   // clock enable low freezes every flop behind the reset release
   a_hold_frozen: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !clk_en |=> $stable(peripheral_interrupt_enables)
                  && $stable(sfr_rdata) && $stable(irq_req))
      else $error("state moved with clock enable low");

   // the released copy may only rise after its first stage
   a_release_order: assert property (
      @(posedge mclk) rst_n |-> rst_meta_n)
      else $error("reset release out of order");

   a_reset_clear: assert property (
      @(posedge mclk) $rose(rst_n)
      |-> irq_req == 8'h00 && sfr_rdata == 8'h00
          && peripheral_interrupt_enables == PIEME_ENABLES_RESET)
      else $error("state not clear after reset");
endmodule
`default_nettype wire

// ==== design/pieme_pkg.sv ====
package pieme_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] PIEME_ENABLES_ADDR  = 8'he6;
   localparam logic [7:0] PIEME_ENABLES_RESET = 8'h00;
   localparam logic [7:0] PIEME_RESERVED_MASK = 8'h02;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int PIEME_BIT_TIMER3  = 7;
   localparam int PIEME_BIT_CMP1    = 6;
   localparam int PIEME_BIT_CMP0    = 5;
   localparam int PIEME_BIT_CNTARR  = 4;
   localparam int PIEME_BIT_CONV    = 3;
   localparam int PIEME_BIT_WINDOW  = 2;
   localparam int PIEME_BIT_RSVD    = 1;
   localparam int PIEME_BIT_TWOWIRE = 0;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pieme_sfr_req_s;

   // raw peripheral flags, one field per flag, so each comparator has a rise and a fall field
   typedef struct packed {
      logic timer_three_flag;
      logic comparator_one_rise_flag;
      logic comparator_one_fall_flag;
      logic comparator_zero_rise_flag;
      logic comparator_zero_fall_flag;
      logic counter_array_flag;
      logic conversion_done_flag;
      logic window_compare_flag;
      logic two_wire_flag;
   } pieme_src_s;

   // gated requests toward the core, bit order matches the register
   typedef logic [7:0] pieme_req_t;
endpackage

// ==== design/pieme_gate.sv ====
`timescale 1ns/100ps
`default_nettype none
module pieme_gate
   import pieme_pkg::*;
(
   input  wire pieme_pkg::pieme_src_s src,
   input  wire logic [7:0]            enables,
   output logic [7:0]                 gated
);
   wire logic [7:0] raw;

   // two-flag sources collapse into one request before gating
   assign raw[PIEME_BIT_TIMER3]  = src.timer_three_flag;
   assign raw[PIEME_BIT_CMP1]    = src.comparator_one_rise_flag
                                 | src.comparator_one_fall_flag;
   assign raw[PIEME_BIT_CMP0]    = src.comparator_zero_rise_flag
                                 | src.comparator_zero_fall_flag;
   assign raw[PIEME_BIT_CNTARR]  = src.counter_array_flag;
   assign raw[PIEME_BIT_CONV]    = src.conversion_done_flag;
   assign raw[PIEME_BIT_WINDOW]  = src.window_compare_flag;
   assign raw[PIEME_BIT_RSVD]    = 1'b0;
   assign raw[PIEME_BIT_TWOWIRE] = src.two_wire_flag;

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_mask
         assign gated[g] = raw[g] & enables[g];
      end
   endgenerate
endmodule
`default_nettype wire

// ==== testbench/pieme_src_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// peripheral flag sources, one register stage like real flags
// ------------------------------------------------------------
module pieme_src_model
   import pieme_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic [8:0]           flags,
   output var pieme_pkg::pieme_src_s src
);
   import pieme_pkg::*;
   always_ff @(posedge mclk) begin
      src <= pieme_src_s'(flags);
   end
endmodule
`default_nettype wire

// ==== testbench/tb_peripheral_interrupt_enable_mask.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_peripheral_interrupt_enable_mask;
   import pieme_pkg::*;
   logic           mclk, arst_n, clk_en, hit;
   pieme_sfr_req_s req;
   logic [7:0]     rdata, irq, got;
   logic [8:0]     flags;
   pieme_src_s     src;
   int             n_mismatch = 0, checks = 0, cyc = 0;
   pieme_top i_dut (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
      .sfr_req(req), .sfr_rdata(rdata), .sfr_hit(hit), .src(src),
      .irq_req(irq));
   pieme_src_model i_src (.mclk(mclk), .flags(flags), .src(src));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // one strobe cycle, then an idle cycle before the next request
   task automatic sfr(logic w, logic [7:0] a, logic [7:0] d);
      @(posedge mclk) #1;
      // software side keeps the reserved position at zero
      req = '{w, !w, a, d & ~PIEME_RESERVED_MASK};
      #10 check("hit", {7'h00, hit}, {7'h00, a == PIEME_ENABLES_ADDR});
      @(posedge mclk) #1;
      got = rdata;
      req = '0;
   endtask
   function automatic logic [7:0] exp_irq(logic [7:0] en, logic [8:0] f);
      return en & {f[8], f[7] | f[6], f[5] | f[4], f[3:1], 1'b0, f[0]};
   endfunction
   task automatic drive_src(logic [7:0] en, logic [8:0] f);
      @(posedge mclk) #1 flags = f;
      // model stage plus the registered gate
      repeat (2) @(posedge mclk);
      #1 check("irq_req", irq, exp_irq(en, f));
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      req = '0;
      flags = 9'h1ff;
      repeat (3) @(posedge mclk);
      #1 arst_n = 1'b1;
      repeat (3) @(posedge mclk);
      sfr(1'b0, PIEME_ENABLES_ADDR, 8'h00);
      check("reset value", got, PIEME_ENABLES_RESET);
      drive_src(8'h00, 9'h1ff);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         sfr(1'b1, PIEME_ENABLES_ADDR, 8'h01 << i);
         sfr(1'b0, PIEME_ENABLES_ADDR, 8'h00);
         check("readback", got, (8'h01 << i) & ~PIEME_RESERVED_MASK);
         drive_src(8'h01 << i, 9'h1ff);
         drive_src(8'h01 << i, 9'h0a0);
         drive_src(8'h01 << i, 9'h050);
         sfr(1'b1, PIEME_ENABLES_ADDR, ~(8'h01 << i));
         drive_src(~(8'h01 << i), 9'h1ff);
      end
      $display("gating test done");
      sfr(1'b1, PIEME_ENABLES_ADDR, 8'hff);
      sfr(1'b1, 8'he5, 8'h00);
      sfr(1'b0, 8'he5, 8'h00);
      check("unmapped read", got, 8'h00);
      clk_en = 1'b0;
      sfr(1'b1, PIEME_ENABLES_ADDR, 8'h00);
      clk_en = 1'b1;
      sfr(1'b0, PIEME_ENABLES_ADDR, 8'h00);
      check("held value", got, 8'hfd);
      drive_src(8'hfd, 9'h1ff);
      // sources drop while the enable is low: requests must hold
      clk_en = 1'b0;
      @(posedge mclk) #1 flags = 9'h000;
      repeat (2) @(posedge mclk);
      #1 check("frozen irq_req", irq, 8'hfd);
      clk_en = 1'b1;
      drive_src(8'hfd, 9'h000);
      $display("access test done");
      give_verdict();
   end
endmodule
`default_nettype wire
